// File: fmsp_map.svh
// Register offsets, field positions, reset values and timing counts of the serial port.
`ifndef FMSP_MAP_SVH
`define FMSP_MAP_SVH
`define FMSP_CTRL_ADDR   8'h98
`define FMSP_DATA_ADDR   8'h99
`define FMSP_AUX_ADDR    8'h9a
`define FMSP_BIT_MODE_HI 7
`define FMSP_BIT_MODE_LO 6
`define FMSP_BIT_MPF     5
`define FMSP_BIT_REN     4
`define FMSP_BIT_TB8     3
`define FMSP_BIT_RB8     2
`define FMSP_BIT_TI      1
`define FMSP_BIT_RI      0
`define FMSP_BIT_FAST    0
`define FMSP_CTRL_RESET  8'h00
`define FMSP_AUX_RESET   8'h00
`define FMSP_OVERSAMPLE  16
`define FMSP_MID_TICK    4'h7
`define FMSP_LAST_TICK   4'hf
`define FMSP_M0_DIV      12
`define FMSP_M0_LAST     4'(`FMSP_M0_DIV - 1)
`define FMSP_M0_RISE     4'(`FMSP_M0_DIV / 2)
`define FMSP_M2_SLOW     3'(64 / `FMSP_OVERSAMPLE)
`define FMSP_M2_FAST     3'(32 / `FMSP_OVERSAMPLE)
`endif

// File: fmsp_pkg.sv
// Types used by the serial port design.
package fmsp_pkg;
  typedef enum logic [1:0] {FMSP_MODE0, FMSP_MODE1, FMSP_MODE2, FMSP_MODE3} fmsp_mode_type;
  typedef enum logic {FMSP_TX_IDLE, FMSP_TX_BITS} fmsp_tx_state_type;
  typedef enum logic {FMSP_RX_IDLE, FMSP_RX_BITS} fmsp_rx_state_type;
  typedef enum logic [1:0] {FMSP_M0_IDLE, FMSP_M0_TX, FMSP_M0_RX} fmsp_m0_state_type;
endpackage

// File: fmsp_serial_port.sv
// Four-mode serial port with control, data and rate registers.
// Function
// - Transmit and receive run together in modes 1 to 3; a second byte may arrive before reading.
// - Data write loads transmitter; data read returns separate receive holding register.
// - Mode 0 shifts 8 bits LSB first on rxd, shift clock on txd.
// - Mode 1 frame: start 0, 8 data bits LSB first, stop 1.
// - Mode 1 without filtering stores received stop bit in rx_ninth_bit.
// - Mode 2 frame adds tx_ninth_bit; rate is clock/64 or clock/32.
// - Modes 2 and 3 store received ninth bit and ignore stop bit.
// - Mode 3 equals mode 2 but uses the variable baud tick.
// - Any data register write starts a transmission in modes 1 to 3; in mode 0 only while the shift engine is idle.
// - Mode 0 reception starts when rx_done_flag clear and receive enable set.
// - Modes 1 to 3 start receiving on a start bit while enabled.
// - With filtering in modes 2 and 3, ninth bit 0 sets no flag.
// - With filtering in mode 1, an invalid stop bit sets no flag.
// - Only software changes receive enable; while clear no reception begins.
// - tx_done_flag set after eighth mode 0 bit or at stop start.
// - rx_done_flag set after eighth mode 0 bit or mid stop bit.
// - Two mode bits select shift register, 8-bit, 9-bit fixed, 9-bit variable.
`timescale 1ns/1ps
`include "fmsp_map.svh"

module fmsp_serial_port (
  input  wire logic       clock,     // System clock, 100 MHz.
  input  wire logic       reset_n,   // Asynchronous reset, active low.
  input  wire logic [7:0] reg_addr,  // Register address.
  input  wire logic [7:0] reg_wdata, // Register write data.
  input  wire logic       reg_wr,    // Write strobe.
  input  wire logic       reg_rd,    // Read strobe.
  output logic      [7:0] reg_rdata, // Read data, valid the cycle after the strobe.
  input  wire logic       baud_tick, // Timer overflow, one pulse per sixteenth bit.
  input  wire logic       rxd_in,    // Level seen on the receive data pin.
  output logic            rxd_out,   // Mode 0 data driven onto the receive data pin.
  output logic            rxd_oe,    // High while the port drives the receive data pin.
  output logic            txd        // Serial output or mode 0 shift clock.
);

  fmsp_pkg::fmsp_mode_type     mode, next_mode;
  fmsp_pkg::fmsp_tx_state_type tx_state, next_tx_state;
  fmsp_pkg::fmsp_rx_state_type rx_state, next_rx_state;
  fmsp_pkg::fmsp_m0_state_type m0_state, next_m0_state;
  logic       mpf, ren, tb8, rb8, ti, ri, fast;
  logic       next_mpf, next_ren, next_tb8, next_rb8, next_ti, next_ri, next_fast;
  logic [7:0] rx_hold, next_rx_hold, next_rdata;
  logic [2:0] div_cnt, next_div_cnt;
  logic       tick;
  logic [10:0] tx_shift, next_tx_shift;
  logic [3:0] tx_cnt, next_tx_cnt, tx_left, next_tx_left;
  logic       tx_set_ti;
  logic [7:0] rx_shift, next_rx_shift;
  logic [3:0] rx_cnt, next_rx_cnt, rx_idx, next_rx_idx;
  logic       rx_ninth, next_rx_ninth, rx_prev, next_rx_prev;
  logic       rx_fin, rx_fin_bit;
  logic [3:0] m0_phase, next_m0_phase;
  logic [2:0] m0_bit, next_m0_bit;
  logic [7:0] m0_shift, next_m0_shift;
  logic       m0_tx_fin, m0_rx_fin;
  logic       next_txd, next_rxd_out, next_rxd_oe;
  logic       data_wr, ctrl_wr, async_mode, async_go;

  assign data_wr    = reg_wr && (reg_addr == `FMSP_DATA_ADDR);
  assign ctrl_wr    = reg_wr && (reg_addr == `FMSP_CTRL_ADDR);
  assign async_mode = (mode != fmsp_pkg::FMSP_MODE0);
  assign async_go   = data_wr && async_mode;

  // Sixteenth-bit tick: fixed divider in mode 2, timer overflow otherwise.
  // A data write restarts the divider so the start bit gets its full length.
  // A receive in flight may see one long tick interval then, well inside its margin.
  always_comb begin
    next_div_cnt = div_cnt + 3'h1;
    if (div_cnt >= ((fast ? `FMSP_M2_FAST : `FMSP_M2_SLOW) - 3'h1)) begin
      next_div_cnt = 3'h0;
    end
    if (async_go) begin
      next_div_cnt = 3'h0;
    end
  end

  assign tick = (mode == fmsp_pkg::FMSP_MODE2)
              ? (div_cnt >= ((fast ? `FMSP_M2_FAST : `FMSP_M2_SLOW) - 3'h1))
              : baud_tick;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // Asynchronous transmitter; the frame is loaded LSB first with the start bit.
  always_comb begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_cnt   = tx_cnt;
    next_tx_left  = tx_left;
    tx_set_ti     = 1'b0;
    case (tx_state)
      fmsp_pkg::FMSP_TX_IDLE: begin
        next_tx_shift = 11'h7ff;
      end
      fmsp_pkg::FMSP_TX_BITS: begin
        if (tick) begin
          next_tx_cnt = tx_cnt + 4'h1;
          if (tx_cnt == `FMSP_LAST_TICK) begin
            next_tx_shift = {1'b1, tx_shift[10:1]};
            next_tx_left  = tx_left - 4'h1;
            tx_set_ti     = (tx_left == 4'h2);
            if (tx_left == 4'h1) begin
              next_tx_state = fmsp_pkg::FMSP_TX_IDLE;
            end
          end
        end
      end
      default: begin
        next_tx_state = fmsp_pkg::FMSP_TX_IDLE;
      end
    endcase
    if (async_go) begin
      next_tx_state = fmsp_pkg::FMSP_TX_BITS;
      next_tx_cnt   = 4'h0;
      if (mode == fmsp_pkg::FMSP_MODE1) begin
        next_tx_shift = {2'b11, reg_wdata, 1'b0};
        next_tx_left  = 4'd10;
      end else begin
        next_tx_shift = {1'b1, tb8, reg_wdata, 1'b0};
        next_tx_left  = 4'd11;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= fmsp_pkg::FMSP_TX_IDLE;
      tx_shift <= 11'h7ff;
      tx_cnt   <= 4'h0;
      tx_left  <= 4'h0;
    end else begin
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_cnt   <= next_tx_cnt;
      tx_left  <= next_tx_left;
    end
  end

  // Asynchronous receiver, sampling each bit at its middle tick.
  always_comb begin
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_cnt   = rx_cnt;
    next_rx_idx   = rx_idx;
    next_rx_ninth = rx_ninth;
    next_rx_prev  = rxd_in;
    rx_fin        = 1'b0;
    rx_fin_bit    = 1'b0;
    case (rx_state)
      fmsp_pkg::FMSP_RX_IDLE: begin
        if (ren && async_mode && rx_prev && !rxd_in) begin
          next_rx_state = fmsp_pkg::FMSP_RX_BITS;
          next_rx_cnt   = 4'h0;
          next_rx_idx   = 4'h0;
        end
      end
      fmsp_pkg::FMSP_RX_BITS: begin
        if (tick) begin
          next_rx_cnt = rx_cnt + 4'h1;
          if (rx_cnt == `FMSP_MID_TICK) begin
            next_rx_idx = rx_idx + 4'h1;
            if (rx_idx == 4'h0) begin
              if (rxd_in) begin
                next_rx_state = fmsp_pkg::FMSP_RX_IDLE;
              end
            end else if (rx_idx <= 4'd8) begin
              next_rx_shift = {rxd_in, rx_shift[7:1]};
            end else if (rx_idx == 4'd9 && mode != fmsp_pkg::FMSP_MODE1) begin
              next_rx_ninth = rxd_in;
            end else begin
              rx_fin        = 1'b1;
              next_rx_state = fmsp_pkg::FMSP_RX_IDLE;
              // Mode 1 keeps the stop bit; modes 2 and 3 keep the ninth bit.
              rx_fin_bit = (mode == fmsp_pkg::FMSP_MODE1) ? rxd_in : rx_ninth;
            end
          end
        end
      end
      default: begin
        next_rx_state = fmsp_pkg::FMSP_RX_IDLE;
      end
    endcase
    if (!async_mode) begin
      next_rx_state = fmsp_pkg::FMSP_RX_IDLE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= fmsp_pkg::FMSP_RX_IDLE;
      rx_shift <= 8'h00;
      rx_cnt   <= 4'h0;
      rx_idx   <= 4'h0;
      rx_ninth <= 1'b0;
      rx_prev  <= 1'b1;
    end else begin
      rx_state <= next_rx_state;
      rx_shift <= next_rx_shift;
      rx_cnt   <= next_rx_cnt;
      rx_idx   <= next_rx_idx;
      rx_ninth <= next_rx_ninth;
      rx_prev  <= next_rx_prev;
    end
  end

  // Mode 0 shift engine; one bit takes twelve clocks, clock low then high.
  always_comb begin
    next_m0_state = m0_state;
    next_m0_phase = m0_phase;
    next_m0_bit   = m0_bit;
    next_m0_shift = m0_shift;
    m0_tx_fin     = 1'b0;
    m0_rx_fin     = 1'b0;
    case (m0_state)
      fmsp_pkg::FMSP_M0_IDLE: begin
        if (!async_mode && data_wr) begin
          next_m0_state = fmsp_pkg::FMSP_M0_TX;
          next_m0_shift = reg_wdata;
          next_m0_phase = 4'h0;
          next_m0_bit   = 3'h0;
        end else if (!async_mode && ren && !ri) begin
          next_m0_state = fmsp_pkg::FMSP_M0_RX;
          next_m0_phase = 4'h0;
          next_m0_bit   = 3'h0;
        end
      end
      fmsp_pkg::FMSP_M0_TX, fmsp_pkg::FMSP_M0_RX: begin
        next_m0_phase = m0_phase + 4'h1;
        if (m0_state == fmsp_pkg::FMSP_M0_RX && m0_phase == `FMSP_M0_RISE) begin
          next_m0_shift = {rxd_in, m0_shift[7:1]};
        end
        if (m0_phase == `FMSP_M0_LAST) begin
          next_m0_phase = 4'h0;
          next_m0_bit   = m0_bit + 3'h1;
          if (m0_state == fmsp_pkg::FMSP_M0_TX) begin
            next_m0_shift = {1'b1, m0_shift[7:1]};
          end
          if (m0_bit == 3'h7) begin
            m0_tx_fin     = (m0_state == fmsp_pkg::FMSP_M0_TX);
            m0_rx_fin     = (m0_state == fmsp_pkg::FMSP_M0_RX);
            next_m0_state = fmsp_pkg::FMSP_M0_IDLE;
          end
        end
      end
      default: begin
        next_m0_state = fmsp_pkg::FMSP_M0_IDLE;
      end
    endcase
    if (async_mode) begin
      next_m0_state = fmsp_pkg::FMSP_M0_IDLE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      m0_state <= fmsp_pkg::FMSP_M0_IDLE;
      m0_phase <= 4'h0;
      m0_bit   <= 3'h0;
      m0_shift <= 8'h00;
    end else begin
      m0_state <= next_m0_state;
      m0_phase <= next_m0_phase;
      m0_bit   <= next_m0_bit;
      m0_shift <= next_m0_shift;
    end
  end

  // Software registers; a hardware set wins over a software clear.
  always_comb begin
    next_mode    = mode;
    next_mpf     = mpf;
    next_ren     = ren;
    next_tb8     = tb8;
    next_rb8     = rb8;
    next_ti      = ti;
    next_ri      = ri;
    next_fast    = fast;
    next_rx_hold = rx_hold;
    next_rdata   = 8'h00;
    if (ctrl_wr) begin
      next_mode = fmsp_pkg::fmsp_mode_type'(reg_wdata[`FMSP_BIT_MODE_HI:`FMSP_BIT_MODE_LO]);
      next_mpf  = reg_wdata[`FMSP_BIT_MPF];
      next_ren  = reg_wdata[`FMSP_BIT_REN];
      next_tb8  = reg_wdata[`FMSP_BIT_TB8];
      next_rb8  = reg_wdata[`FMSP_BIT_RB8];
      next_ti   = reg_wdata[`FMSP_BIT_TI];
      next_ri   = reg_wdata[`FMSP_BIT_RI];
    end
    if (reg_wr && reg_addr == `FMSP_AUX_ADDR) begin
      next_fast = reg_wdata[`FMSP_BIT_FAST];
    end
    if (tx_set_ti || m0_tx_fin) begin
      next_ti = 1'b1;
    end
    // An unread byte blocks the load, so the newer character is dropped.
    if (rx_fin && !ri && (!mpf || rx_fin_bit)) begin
      next_rx_hold = rx_shift;
      next_rb8     = rx_fin_bit;
      next_ri      = 1'b1;
    end
    if (m0_rx_fin) begin
      next_rx_hold = next_m0_shift;
      next_ri      = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        `FMSP_CTRL_ADDR: next_rdata = {mode, mpf, ren, tb8, rb8, ti, ri};
        `FMSP_DATA_ADDR: next_rdata = rx_hold;
        `FMSP_AUX_ADDR:  next_rdata = {7'h00, fast};
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode      <= fmsp_pkg::fmsp_mode_type'(`FMSP_CTRL_RESET >> `FMSP_BIT_MODE_LO);
      mpf       <= 1'(`FMSP_CTRL_RESET >> `FMSP_BIT_MPF);
      ren       <= 1'(`FMSP_CTRL_RESET >> `FMSP_BIT_REN);
      tb8       <= 1'(`FMSP_CTRL_RESET >> `FMSP_BIT_TB8);
      rb8       <= 1'(`FMSP_CTRL_RESET >> `FMSP_BIT_RB8);
      ti        <= 1'(`FMSP_CTRL_RESET >> `FMSP_BIT_TI);
      ri        <= 1'(`FMSP_CTRL_RESET >> `FMSP_BIT_RI);
      fast      <= 1'(`FMSP_AUX_RESET >> `FMSP_BIT_FAST);
      rx_hold   <= 8'h00;
      reg_rdata <= 8'h00;
    end else begin
      mode      <= next_mode;
      mpf       <= next_mpf;
      ren       <= next_ren;
      tb8       <= next_tb8;
      rb8       <= next_rb8;
      ti        <= next_ti;
      ri        <= next_ri;
      fast      <= next_fast;
      rx_hold   <= next_rx_hold;
      reg_rdata <= next_rdata;
    end
  end

  // Pin drivers; in mode 0 txd carries the shift clock and rxd the data.
  always_comb begin
    next_txd     = tx_shift[0];
    next_rxd_out = 1'b1;
    next_rxd_oe  = 1'b0;
    if (!async_mode) begin
      next_txd = 1'b1;
      if (m0_state != fmsp_pkg::FMSP_M0_IDLE) begin
        // The registered phase keeps the first low half as long as the others.
        next_txd = (m0_phase >= `FMSP_M0_RISE);
      end
      if (m0_state == fmsp_pkg::FMSP_M0_TX) begin
        next_rxd_out = next_m0_shift[0];
        next_rxd_oe  = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txd     <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end else begin
      txd     <= next_txd;
      rxd_out <= next_rxd_out;
      rxd_oe  <= next_rxd_oe;
    end
  end

endmodule

// File: fmsp_props.sv
// Concurrent checks on the serial port register port and pins.
`timescale 1ns/1ps
`include "fmsp_map.svh"
module fmsp_props (
  input wire logic       clock,     // Clock.
  input wire logic       reset_n,   // Reset, active low.
  input wire logic [7:0] reg_addr,  // Address.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic       reg_wr,    // Write strobe.
  input wire logic       reg_rd,    // Read strobe.
  input wire logic [7:0] reg_rdata, // Read data.
  input wire logic       baud_tick, // Baud tick.
  input wire logic       rxd_in,    // Data pin level.
  input wire logic       rxd_out,   // Mode 0 data.
  input wire logic       rxd_oe,    // Mode 0 drive.
  input wire logic       txd        // Serial out.
);
  logic [1:0] mode;
  logic       fast;
  logic [7:0] wd;
  logic       wrd;
  // Shadows of the mode bits, rate bit and last transmitted byte.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode <= 2'h0;
      fast <= 1'b0;
      wd   <= 8'h00;
    end else if (reg_wr && reg_addr == `FMSP_CTRL_ADDR) begin
      mode <= reg_wdata[7:6];
    end else if (reg_wr && reg_addr == `FMSP_AUX_ADDR) begin
      fast <= reg_wdata[0];
    end else if (wrd) begin
      wd <= reg_wdata;
    end
  end
  assign wrd = reg_wr && reg_addr == `FMSP_DATA_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence m0_low_s; !txd [*6] ##1 txd; endsequence
  sequence slow_start_s; !txd [*8] ##56 !txd; endsequence
  sequence fast_start_s; !txd [*8] ##24 !txd; endsequence
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  tx_start_a: assert property (wrd && mode != 2'h0 |-> ##2 !txd)
    else $error("no start bit after data write");
  m0_first_a: assert property (wrd && mode == 2'h0 |-> ##2 rxd_oe && !txd && rxd_out == wd[0])
    else $error("mode 0 first bit wrong");
  m0_low_a: assert property ($fell(txd) && mode == 2'h0 |-> m0_low_s)
    else $error("mode 0 clock low phase wrong");
  m0_high_a: assert property ($rose(txd) && mode == 2'h0 |-> txd [*6])
    else $error("mode 0 clock high phase wrong");
  oe_mode_a: assert property (rxd_oe |-> mode == 2'h0)
    else $error("data pin driven outside mode 0");
  oe_hold_a: assert property ($rose(rxd_oe) |-> rxd_oe [*8])
    else $error("mode 0 drive too short");
  slow_frame_a: assert property (wrd && mode == 2'h2 && !fast |->
    ##2 slow_start_s ##1 txd == wd[0])
    else $error("slow mode 2 bit time wrong");
  fast_frame_a: assert property (wrd && mode == 2'h2 && fast |->
    ##2 fast_start_s ##1 txd == wd[0])
    else $error("fast mode 2 bit time wrong");
endmodule
bind fmsp_serial_port fmsp_props i_fmsp_props (.clock(clock), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .baud_tick(baud_tick), .rxd_in(rxd_in), .rxd_out(rxd_out),
  .rxd_oe(rxd_oe), .txd(txd));

// File: fmsp_peer.sv
// Far-side serial device: frame sender, frame decoder and shift partner.
`timescale 1ns/1ps
module fmsp_peer (
  input  wire logic       clock,   // Clock.
  input  wire logic       reset_n, // Reset, active low.
  input  wire logic       go,      // Send one frame.
  input  wire logic [7:0] tb,      // Byte to send.
  input  wire logic       t9,      // Frame has a ninth bit.
  input  wire logic       t9v,     // Ninth bit value.
  input  wire logic       tstop,   // Stop bit value.
  input  wire logic [7:0] bl,      // Bit length in clocks.
  input  wire logic       m0,      // Shift register role.
  input  wire logic [7:0] m0b,     // Byte offered in that role.
  input  wire logic       txd,     // Port serial out.
  input  wire logic       rxd_out, // Port mode 0 data.
  input  wire logic       rxd_oe,  // Port drives data pin.
  output logic            rxd_in,  // Data pin level.
  output logic            rv,      // Frame decoded.
  output logic      [8:0] rb,      // Ninth bit and byte.
  output logic            busy     // Frame in flight.
);
  logic [10:0] f;
  logic [11:0] tc;
  logic [11:0] rc;
  logic [7:0]  sh;
  logic [2:0]  n;
  logic [2:0]  r;
  logic [2:0]  idx;
  logic        line;
  logic        tp;
  // The idle line rests high; mode 0 offers the byte bit chosen at each clock fall.
  assign line   = (tc == 12'h000) ? 1'b1 : f[tc / bl];
  assign rxd_in = rxd_oe ? rxd_out : (m0 ? m0b[idx] : line);
  assign busy   = tc != 12'h000 || rc != 12'h000;
  // Sender, serial decoder and mode 0 shift logic.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {tc, rc, sh, n, r, idx, rv, rb, f} <= '0;
      tp <= 1'b1;
    end else begin
      tp <= txd;
      rv <= 1'b0;
      if (go) begin
        f  <= t9 ? {tstop, t9v, tb, 1'b0} : {1'b1, tstop, tb, 1'b0};
        tc <= 12'h001;
      end else if (tc != 12'h000) begin
        tc <= (tc == 11 * bl - 1) ? 12'h000 : tc + 12'h001;
      end
      if (!m0 && !rxd_oe && rc == 12'h000 && tp && !txd) begin
        rc <= 12'h001;
      end else if (rc != 12'h000) begin
        if (rc % bl == bl / 2 && rc > bl && rc < 10 * bl) rb <= {txd, rb[8:1]};
        rv <= rc == 11 * bl;
        rc <= (rc == 11 * bl) ? 12'h000 : rc + 12'h001;
      end
      if (m0 && txd && !tp) r <= r + 3'h1;
      if (m0 && !txd && tp) idx <= r;
      if (m0 && rxd_oe && txd && !tp) begin
        sh <= {rxd_out, sh[7:1]};
        n  <= n + 3'h1;
        rv <= n == 3'h7;
        rb <= {1'b0, rxd_out, sh[7:1]};
      end
    end
  end
endmodule

// File: testbench.sv
// Self-checking bench for the four-mode serial port.
`timescale 1ns/1ps
`include "fmsp_map.svh"
module testbench;
  logic        clock = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, baud_tick = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, tb = 8'h00, bl = 8'd64;
  logic [7:0]  m0b = 8'h00, b1, b2;
  logic        rxd_in, rxd_out, rxd_oe, txd, rv, busy, rd_d = 1'b0;
  logic        go = 1'b0, m0 = 1'b0, t9 = 1'b0, t9v = 1'b0, tstop = 1'b1;
  logic [8:0]  rb;
  logic [1:0]  bcnt = 2'h0;
  logic [31:0] seed = 32'hd29ef3f1;
  logic [7:0]  q_rd[$];
  logic [8:0]  q_fr[$];
  int          fail_count = 0, n_tests = 0;
  fmsp_serial_port i_fmsp_serial_port (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .baud_tick(baud_tick), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
  fmsp_peer i_fmsp_peer (.clock(clock), .reset_n(reset_n), .go(go), .tb(tb), .t9(t9),
    .t9v(t9v), .tstop(tstop), .bl(bl), .m0(m0), .m0b(m0b), .txd(txd), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .rxd_in(rxd_in), .rv(rv), .rb(rb), .busy(busy));
  // Clock and a baud tick every fourth clock, sixteen ticks to a 64-clock bit.
  always #5 clock = ~clock;
  always @(posedge clock) begin
    bcnt <= bcnt + 2'h1;
    baud_tick <= bcnt == 2'h3;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    q_rd.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d, input logic n9, input logic v9, input logic sp);
    @(posedge clock);
    tb    <= d;
    t9    <= n9;
    t9v   <= v9;
    tstop <= sp;
    go    <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
  endtask
  task automatic settle(input int n);
    int k = 0;
    repeat (n) @(posedge clock);
    while (busy === 1'b1 && k < 3000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 3000) begin
      fail_count++;
      summarize();
    end
    repeat (8) @(posedge clock);
  endtask
  // Read answers and decoded frames are compared with the oldest note as they appear.
  always @(posedge clock) begin
    rd_d <= reg_rd;
    if (rd_d) chk(reg_rdata, q_rd.pop_front(), "reg_rdata");
    if (rv === 1'b1) chk(rb, q_fr.pop_front(), "frame");
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    chk(txd, 9'h001, "txd idle");
    rd(`FMSP_CTRL_ADDR, `FMSP_CTRL_RESET);
    rd(`FMSP_AUX_ADDR, `FMSP_AUX_RESET);
    rd(8'h9b, 8'h00);
    b1 = rnd();
    wr(`FMSP_CTRL_ADDR, 8'h40);
    q_fr.push_back({1'b1, b1});
    send(rnd(), 1'b0, 1'b0, 1'b1);
    wr(`FMSP_DATA_ADDR, b1);
    settle(4);
    rd(`FMSP_CTRL_ADDR, 8'h42);
    wr(`FMSP_CTRL_ADDR, 8'h50);
    b1 = rnd();
    b2 = rnd();
    q_fr.push_back({1'b1, b2});
    send(b1, 1'b0, 1'b0, 1'b1);
    wr(`FMSP_DATA_ADDR, b2);
    settle(4);
    rd(`FMSP_CTRL_ADDR, 8'h57);
    rd(`FMSP_DATA_ADDR, b1);
    send(rnd(), 1'b0, 1'b0, 1'b1);
    settle(4);
    rd(`FMSP_DATA_ADDR, b1);
    wr(`FMSP_CTRL_ADDR, 8'h70);
    send(rnd(), 1'b0, 1'b0, 1'b0);
    settle(4);
    rd(`FMSP_CTRL_ADDR, 8'h70);
    for (int m = 2; m < 4; m++) begin
      wr(`FMSP_CTRL_ADDR, {m[1:0], 6'h30});
      send(rnd(), 1'b1, 1'b0, 1'b1);
      settle(4);
      rd(`FMSP_CTRL_ADDR, {m[1:0], 6'h30});
      b1 = rnd();
      send(b1, 1'b1, 1'b1, 1'b0);
      settle(4);
      rd(`FMSP_CTRL_ADDR, {m[1:0], 6'h35});
      rd(`FMSP_DATA_ADDR, b1);
      wr(`FMSP_CTRL_ADDR, {m[1:0], 6'h08});
      b1 = rnd();
      q_fr.push_back({1'b1, b1});
      wr(`FMSP_DATA_ADDR, b1);
      settle(4);
      rd(`FMSP_CTRL_ADDR, {m[1:0], 6'h0a});
    end
    wr(`FMSP_CTRL_ADDR, 8'h80);
    wr(`FMSP_AUX_ADDR, 8'h01);
    bl <= 8'd32;
    b1 = rnd();
    q_fr.push_back({1'b0, b1});
    wr(`FMSP_DATA_ADDR, b1);
    settle(4);
    wr(`FMSP_CTRL_ADDR, 8'h00);
    m0 <= 1'b1;
    b1 = rnd();
    q_fr.push_back({1'b0, b1});
    wr(`FMSP_DATA_ADDR, b1);
    settle(130);
    rd(`FMSP_CTRL_ADDR, 8'h02);
    b1 = rnd();
    m0b <= b1;
    wr(`FMSP_CTRL_ADDR, 8'h10);
    settle(130);
    chk(txd, 9'h001, "txd after receive");
    rd(`FMSP_CTRL_ADDR, 8'h11);
    rd(`FMSP_DATA_ADDR, b1);
    repeat (4) @(posedge clock);
    summarize();
  end
endmodule
